// *** logic/bcd_pkg.sv ***
// Constants for the branch, call and external-move decode block.
// Assumes the core supplies fetched bytes, bit values and register values each machine cycle.
// Contract
// - Relative branch: advance past instruction, add offset if acc nonzero, carry set or clear.
// - Bit branches are three bytes, three cycles; set, clear, or set-and-clear.
// - Offset always comes from the last instruction byte.
// - External moves: one byte, two cycles, via R0, R1 or data pointer.
// - Absolute call: counter plus two, push low byte then high byte.
// - Absolute call replaces only low 11 counter bits from opcode and byte two.
// - Page bits come from the incremented counter, so page-end calls reach next page.
// - Add-immediate adds byte two to accumulator and updates arithmetic flags.
// - Add-immediate is two bytes, two machine cycles.
package bcd_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_BR_ACC_NZ   = 8'h70;
  localparam logic [7:0] OP_BR_CARRY    = 8'h40;
  localparam logic [7:0] OP_BR_NCARRY   = 8'h50;
  localparam logic [7:0] OP_BR_BIT_SET  = 8'h20;
  localparam logic [7:0] OP_BR_BIT_CLR  = 8'h30;
  localparam logic [7:0] OP_BR_BIT_CLRB = 8'h10;
  localparam logic [7:0] OP_XRD_RR      = 8'he2;
  localparam logic [7:0] OP_XRD_DP      = 8'he0;
  localparam logic [7:0] OP_XWR_RR      = 8'hf2;
  localparam logic [7:0] OP_XWR_DP      = 8'hf0;
  localparam logic [7:0] OP_ADD_IMM     = 8'h24;
  localparam logic [7:0] OP_NOP         = 8'h00;
  localparam logic [4:0] OP_CALL_LOW    = 5'h11;  // Low five opcode bits of absolute call
  localparam logic [7:0] RR_MASK        = 8'hfe;  // Drop register select bit
  // ---------------------------------------------------------------
  // Flag positions inside the status byte
  // ---------------------------------------------------------------
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  localparam int PSW_P  = 0;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_RESET  = 16'h0000;
  localparam logic [7:0]  ACC_RESET = 8'h00;
  localparam logic [7:0]  PSW_RESET = 8'h00;
  localparam logic [7:0]  SP_RESET  = 8'h07;
  // Machine-cycle states, one-hot
  typedef enum logic [4:0] {
    BCD_FETCH = 5'b00001,
    BCD_B2    = 5'b00010,
    BCD_B3    = 5'b00100,
    BCD_EXEC2 = 5'b01000,
    BCD_PUSH2 = 5'b10000
  } bcd_state_t;
endpackage

// *** logic/bcd_core.sv ***
// Decode and execute of relative branches, bit branches, external moves,
// absolute call, add-immediate and no-operation.
// Assumes one instruction byte arrives per machine cycle on code_byte, the
// bit value, register and external-RAM data are valid when mcycle_en is high.
`timescale 1ns/100ps
module bcd_core
  import bcd_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Machine-cycle enable
  input  wire logic        mcycle_en,
  // Program memory
  input  wire logic [7:0]  code_byte,
  output logic      [15:0] program_counter,
  // Core state in
  input  wire logic [7:0]  bit_value_in,
  input  wire logic [7:0]  reg_r0,
  input  wire logic [7:0]  reg_r1,
  input  wire logic [15:0] data_pointer,
  // External data RAM
  input  wire logic [7:0]  xram_rdata,
  output logic      [15:0] xram_addr,
  output logic      [7:0]  xram_wdata,
  output logic             xram_rd,
  output logic             xram_wr,
  // Bit clear request
  output logic      [7:0]  bit_addr,
  output logic             bit_clear,
  // Stack write
  output logic      [7:0]  stack_pointer,
  output logic      [7:0]  stack_wdata,
  output logic             stack_wr,
  // Architectural state out
  output logic      [7:0]  acc,
  output logic      [7:0]  program_status_flags,
  output logic             instr_done
);
  import bcd_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
    rel_target = pc + {{8{off[7]}}, off};
  endfunction

  function automatic logic is_call(input logic [7:0] op);
    is_call = (op[4:0] == OP_CALL_LOW);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bcd_state_t  st_q, st_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  op_q, op_d;
  logic [7:0]  b2_q, b2_d;
  logic [7:0]  acc_q, acc_d;
  logic [7:0]  psw_q, psw_d;
  logic [7:0]  sp_q, sp_d;
  logic [15:0] xa_q, xa_d;
  logic [7:0]  xw_q, xw_d;
  logic        xrd_q, xrd_d, xwr_q, xwr_d;
  logic        bclr_q, bclr_d;
  logic [7:0]  swd_q, swd_d;
  logic        swr_q, swr_d;
  logic        done_q, done_d;
  logic [8:0]  sum;
  logic [4:0]  sum_lo;
  logic [7:0]  res;
  logic        taken;

  // Add-immediate arithmetic on the second byte
  always_comb
  begin
    sum    = {1'b0, acc_q} + {1'b0, code_byte};
    sum_lo = {1'b0, acc_q[3:0]} + {1'b0, code_byte[3:0]};
    res    = sum[7:0];
  end

  // Next-state decode; state moves only on a machine-cycle enable, strobes and done clear without it
  always_comb
  begin
    st_d   = st_q;
    pc_d   = pc_q;
    op_d   = op_q;
    b2_d   = b2_q;
    acc_d  = acc_q;
    psw_d  = psw_q;
    sp_d   = sp_q;
    xa_d   = xa_q;
    xw_d   = xw_q;
    xrd_d  = 1'b0;
    xwr_d  = 1'b0;
    bclr_d = 1'b0;
    swd_d  = swd_q;
    swr_d  = 1'b0;
    done_d = 1'b0;
    taken  = 1'b0;
    if (mcycle_en)
    begin
      case (st_q)
        BCD_FETCH:
        begin
          op_d = code_byte;
          pc_d = pc_q + 16'h0001;
          case (code_byte)
            OP_NOP:
              done_d = 1'b1;
            OP_XRD_RR, OP_XRD_RR | 8'h01:
            begin
              xa_d  = {8'h00, code_byte[0] ? reg_r1 : reg_r0};
              xrd_d = 1'b1;
              st_d  = BCD_EXEC2;
            end
            OP_XRD_DP:
            begin
              xa_d  = data_pointer;
              xrd_d = 1'b1;
              st_d  = BCD_EXEC2;
            end
            OP_XWR_RR, OP_XWR_RR | 8'h01:
            begin
              xa_d  = {8'h00, code_byte[0] ? reg_r1 : reg_r0};
              xw_d  = acc_q;
              xwr_d = 1'b1;
              st_d  = BCD_EXEC2;
            end
            OP_XWR_DP:
            begin
              xa_d  = data_pointer;
              xw_d  = acc_q;
              xwr_d = 1'b1;
              st_d  = BCD_EXEC2;
            end
            default:
              st_d = BCD_B2;                         // Multi-byte forms fetch byte two
          endcase
        end
        BCD_B2:
        begin
          b2_d = code_byte;
          pc_d = pc_q + 16'h0001;
          st_d = BCD_FETCH;
          if (op_q == OP_ADD_IMM)
          begin
            acc_d          = res;
            psw_d[PSW_CY]  = sum[8];
            psw_d[PSW_AC]  = sum_lo[4];
            psw_d[PSW_OV]  = (acc_q[7] == code_byte[7]) && (res[7] != acc_q[7]);
            psw_d[PSW_P]   = ^res;
            done_d         = 1'b1;
          end
          else if (op_q == OP_BR_ACC_NZ || op_q == OP_BR_CARRY || op_q == OP_BR_NCARRY)
          begin
            // Counter already past both bytes before the offset is applied
            case (op_q)
              OP_BR_ACC_NZ: taken = (acc_q != 8'h00);
              OP_BR_CARRY:  taken = psw_q[PSW_CY];
              default:      taken = ~psw_q[PSW_CY];
            endcase
            if (taken)
              pc_d = rel_target(pc_q + 16'h0001, code_byte);
            st_d = BCD_EXEC2;
          end
          else if (op_q == OP_BR_BIT_SET || op_q == OP_BR_BIT_CLR || op_q == OP_BR_BIT_CLRB)
            st_d = BCD_B3;
          else if (is_call(op_q))
          begin
            // Push low byte of the already-advanced counter
            sp_d  = sp_q + 8'h01;
            swd_d = pc_d[7:0];
            swr_d = 1'b1;
            st_d  = BCD_PUSH2;
          end
          else
            done_d = 1'b1;                           // Unhandled opcodes skip as two-byte no-ops
        end
        BCD_B3:
        begin
          pc_d = pc_q + 16'h0001;
          case (op_q)
            OP_BR_BIT_SET:  taken = bit_value_in[0];
            OP_BR_BIT_CLR:  taken = ~bit_value_in[0];
            default:        taken = bit_value_in[0];
          endcase
          if (taken)
            pc_d = rel_target(pc_q + 16'h0001, code_byte);
          bclr_d = taken && (op_q == OP_BR_BIT_CLRB);
          done_d = 1'b1;
          st_d   = BCD_FETCH;
        end
        BCD_PUSH2:
        begin
          sp_d  = sp_q + 8'h01;
          swd_d = pc_q[15:8];
          swr_d = 1'b1;
          // Upper five bits kept from the advanced counter, so page-end calls land next page
          pc_d  = {pc_q[15:11], op_q[7:5], b2_q};
          done_d = 1'b1;
          st_d  = BCD_FETCH;
        end
        BCD_EXEC2:
        begin
          if (op_q == OP_XRD_RR || op_q == (OP_XRD_RR | 8'h01) || op_q == OP_XRD_DP)
            acc_d = xram_rdata;
          done_d = 1'b1;
          st_d   = BCD_FETCH;
        end
        default:
          st_d = BCD_FETCH;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q   <= BCD_FETCH;
      pc_q   <= PC_RESET;
      op_q   <= 8'h00;
      b2_q   <= 8'h00;
      acc_q  <= ACC_RESET;
      psw_q  <= PSW_RESET;
      sp_q   <= SP_RESET;
      xa_q   <= 16'h0000;
      xw_q   <= 8'h00;
      xrd_q  <= 1'b0;
      xwr_q  <= 1'b0;
      bclr_q <= 1'b0;
      swd_q  <= 8'h00;
      swr_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      pc_q   <= pc_d;
      op_q   <= op_d;
      b2_q   <= b2_d;
      acc_q  <= acc_d;
      psw_q  <= psw_d;
      sp_q   <= sp_d;
      xa_q   <= xa_d;
      xw_q   <= xw_d;
      xrd_q  <= xrd_d;
      xwr_q  <= xwr_d;
      bclr_q <= bclr_d;
      swd_q  <= swd_d;
      swr_q  <= swr_d;
      done_q <= done_d;
    end
  end

  // Outputs straight from flip-flops
  assign program_counter      = pc_q;
  assign xram_addr            = xa_q;
  assign xram_wdata           = xw_q;
  assign xram_rd              = xrd_q;
  assign xram_wr              = xwr_q;
  assign bit_addr             = b2_q;
  assign bit_clear            = bclr_q;
  assign stack_pointer        = sp_q;
  assign stack_wdata          = swd_q;
  assign stack_wr             = swr_q;
  assign acc                  = acc_q;
  assign program_status_flags = psw_q;
  assign instr_done           = done_q;
endmodule

// *** testbench/bcd_core_assertions.sv ***
// Checker for bcd_core: moves, call pushes and bit clears.
// Assumes mcycle_en is held high, so steps come on every clock.
`timescale 1ns/100ps
module bcd_core_assertions
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Program and data side
  input wire logic [15:0] program_counter,
  input wire logic [7:0]  xram_wdata,
  input wire logic        xram_rd,
  input wire logic        xram_wr,
  input wire logic        bit_clear,
  // Stack and state
  input wire logic [7:0]  stack_pointer,
  input wire logic [7:0]  stack_wdata,
  input wire logic        stack_wr,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  program_status_flags,
  input wire logic        instr_done
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The two pushes of one call
  sequence s_push_first;
    $rose(stack_wr);
  endsequence
  sequence s_push_pair;
    stack_wr ##1 stack_wr;
  endsequence
  property p_rd_done;
    xram_rd |=> instr_done && !xram_rd;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read move not done in two steps");
  property p_wr_done;
    xram_wr |-> (xram_wdata == acc) ##1 instr_done;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write move data or timing wrong");
  property p_sp_inc;
    s_push_first |-> stack_pointer == $past(stack_pointer) + 8'h01;
  endproperty
  a_sp_inc: assert property (p_sp_inc) else $error("first push without increment");
  property p_push2;
    s_push_first |=> stack_wr && stack_pointer == $past(stack_pointer) + 8'h01;
  endproperty
  a_push2: assert property (p_push2) else $error("second push missing");
  property p_page;
    s_push_pair |-> program_counter[15:11] == stack_wdata[7:3] && instr_done;
  endproperty
  a_page: assert property (p_page) else $error("call page bits wrong");
  property p_flags_call;
    stack_wr |-> $stable(program_status_flags);
  endproperty
  a_flags_call: assert property (p_flags_call) else $error("call changed flags");
  property p_clr_done;
    bit_clear |-> instr_done;
  endproperty
  a_clr_done: assert property (p_clr_done) else $error("bit clear off the last step");
  property p_rd_wr;
    xram_rd |-> !xram_wr;
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read and write together");
endmodule

// *** testbench/bcd_mem_model.sv ***
// Program memory and external data RAM facing bcd_core.
// Assumes the bench preloads code_mem and xram_mem.
`timescale 1ns/100ps
module bcd_mem_model
(
  // Clock
  input  wire logic        ref_clk,
  // Program memory
  input  wire logic [15:0] program_counter,
  output logic      [7:0]  code_byte,
  // External data RAM
  input  wire logic [15:0] xram_addr,
  input  wire logic [7:0]  xram_wdata,
  input  wire logic        xram_rd,
  input  wire logic        xram_wr,
  output logic      [7:0]  xram_rdata
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] code_mem [0:4095];
  logic [7:0] xram_mem [0:255];
  // Only 4K of code and 256 bytes of data are modelled
  assign code_byte = code_mem[program_counter[11:0]];
  // Inverted outside the strobe so a late sample is caught
  assign xram_rdata = xram_rd ? xram_mem[xram_addr[7:0]] : ~xram_mem[xram_addr[7:0]];
  // Write on the strobe
  always @(posedge ref_clk)
    if (xram_wr)
      xram_mem[xram_addr[7:0]] <= xram_wdata;
endmodule

// *** testbench/tb.sv ***
// Bench for bcd_core: runs a short program and checks state.
// Assumes bcd_mem_model as code and data memory.
`timescale 1ns/100ps
module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mcycle_en = 1'b0;
  logic [7:0]  bit_value_in = 8'h01;
  logic [7:0]  reg_r0 = 8'h40;
  logic [7:0]  reg_r1 = 8'h41;
  logic [15:0] data_pointer = 16'h1250;
  logic [15:0] program_counter, xram_addr;
  logic [7:0]  code_byte, xram_rdata, xram_wdata, bit_addr, stack_pointer;
  logic [7:0]  stack_wdata, acc, program_status_flags;
  logic        xram_rd, xram_wr, bit_clear, stack_wr, instr_done;
  logic [7:0]  stk [0:255];
  logic [7:0]  prog [0:46] = '{8'h24, 8'h7f, 8'h24, 8'h01, 8'h70, 8'h02, 8'h00, 8'h00,
    8'h40, 8'h10, 8'h50, 8'h02, 8'h00, 8'h00, 8'h24, 8'h80, 8'h70, 8'h05, 8'h40, 8'h01,
    8'h00, 8'h50, 8'h05, 8'h20, 8'h33, 8'h02, 8'h00, 8'h00, 8'h30, 8'h33, 8'h04, 8'h10,
    8'h33, 8'h01, 8'h00, 8'h10, 8'h33, 8'h05, 8'he2, 8'hf3, 8'he0, 8'h24, 8'h01, 8'hf0,
    8'h00, 8'h71, 8'hfe};
  int          error_cnt = 0;
  int          tests_run = 0;
  int          clr_cnt = 0;
  always #5 ref_clk = ~ref_clk;
  bcd_core bcd_core_i (.ref_clk, .rst_n, .mcycle_en, .code_byte, .program_counter, .bit_value_in,
    .reg_r0, .reg_r1, .data_pointer, .xram_rdata, .xram_addr, .xram_wdata, .xram_rd, .xram_wr,
    .bit_addr, .bit_clear, .stack_pointer, .stack_wdata, .stack_wr, .acc, .program_status_flags,
    .instr_done);
  bcd_mem_model bcd_mem_model_i (.ref_clk, .program_counter, .code_byte, .xram_addr, .xram_wdata,
    .xram_rd, .xram_wr, .xram_rdata);
  // Log pushes and bit clears as they happen
  always @(posedge ref_clk)
  begin
    if (stack_wr)
      stk[stack_pointer] <= stack_wdata;
    if (bit_clear && bit_addr === 8'h33)
      clr_cnt <= clr_cnt + 1;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic final_report();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits for one instruction; flag check skipped when f[8] is set
  task automatic step(input logic [15:0] pc, input logic [7:0] a, input logic [8:0] f);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (instr_done !== 1'b1 && n < 10)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 10)
    begin
      error_cnt++;
      final_report();
    end
    cmp(program_counter, pc);
    cmp({8'h00, acc}, {8'h00, a});
    if (!f[8])
      cmp({8'h00, program_status_flags}, {8'h00, f[7:0]});
  endtask
  // ------------------------------------------------------------
  // Program run
  // ------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 47; i++)
      bcd_mem_model_i.code_mem[i] = prog[i];
    bcd_mem_model_i.code_mem[12'h3fe] = 8'hf1;
    bcd_mem_model_i.code_mem[12'h3ff] = 8'hfe;
    bcd_mem_model_i.code_mem[12'h7fe] = 8'h11;
    bcd_mem_model_i.code_mem[12'h7ff] = 8'h05;
    bcd_mem_model_i.code_mem[12'h805] = 8'h00;
    bcd_mem_model_i.xram_mem[8'h40] = 8'h5a;
    bcd_mem_model_i.xram_mem[8'h50] = 8'hc3;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    mcycle_en = 1'b1;
    step(16'h0002, 8'h7f, 9'h001);
    step(16'h0004, 8'h80, 9'h045);
    step(16'h0008, 8'h80, 9'h045);
    step(16'h000a, 8'h80, 9'h045);
    step(16'h000e, 8'h80, 9'h045);
    step(16'h0010, 8'h00, 9'h084);
    step(16'h0012, 8'h00, 9'h084);
    step(16'h0015, 8'h00, 9'h084);
    step(16'h0017, 8'h00, 9'h084);
    step(16'h001c, 8'h00, 9'h084);
    step(16'h001f, 8'h00, 9'h084);
    step(16'h0023, 8'h00, 9'h084);
    bit_value_in = 8'h00;
    step(16'h0026, 8'h00, 9'h084);
    cmp(clr_cnt[15:0], 16'h0001);
    step(16'h0027, 8'h5a, 9'h100);
    step(16'h0028, 8'h5a, 9'h100);
    step(16'h0029, 8'hc3, 9'h100);
    step(16'h002b, 8'hc4, 9'h001);
    step(16'h002c, 8'hc4, 9'h001);
    step(16'h002d, 8'hc4, 9'h001);
    cmp({8'h00, bcd_mem_model_i.xram_mem[8'h41]}, 16'h005a);
    cmp({8'h00, bcd_mem_model_i.xram_mem[8'h50]}, 16'h00c4);
    step(16'h03fe, 8'hc4, 9'h001);
    step(16'h07fe, 8'hc4, 9'h001);
    step(16'h0805, 8'hc4, 9'h001);
    step(16'h0806, 8'hc4, 9'h001);
    cmp({8'h00, stack_pointer}, 16'h000d);
    cmp({stk[9], stk[8]}, 16'h002f);
    cmp({stk[11], stk[10]}, 16'h0400);
    cmp({stk[13], stk[12]}, 16'h0800);
    final_report();
  end
endmodule
bind bcd_core bcd_core_assertions bcd_core_assertions_i (.ref_clk, .rst_n, .program_counter,
  .xram_wdata, .xram_rd, .xram_wr, .bit_clear, .stack_pointer, .stack_wdata, .stack_wr, .acc,
  .program_status_flags, .instr_done);
